// ===== common/adcp_pkg.sv
// Summary of operation
// - control byte bits 7,6 = 1,0 selects the internal conversion clock
// - internal clock conversion takes a fixed 3.6 us, no host clock needed
// - control byte bits 7,6 = 1,1 clocks conversion from the external clock
// - chip select high: clock, write, read ignored, data pins high-Z
// - a write cycle captures the control byte from all eight data pins
// - byte: 7,6 power mode, 5 acquire, 4 input config, 3 polarity, 2-0 channel
// - result is straight binary when unipolar, two's complement when bipolar
// - low byte read drives result bits 7-0 on data pins 7-0
// - high byte read: bits 9,8 on pins 1,0; pins 7-2 zero or bit 9
// - single-ended: channel n against common return; 4-7 on wide variant only
// - pseudo-differential: bits 2,1 pick pair, bit 0 picks positive input
// - power-on reset enters external clock mode, done output high
// - power-down keeps the bus interface working but performs no conversion
// - standby wakes on the next write strobe rising edge, ready to convert
// - shutdown waits for the running conversion; write rising edge wakes it
// - power codes 00 off, 01 standby, 10 internal, 11 external; keep clock
// - acquire select 0 is internal acquisition, 1 is external acquisition
// - done output low when result ready; high on first read or new write
// - external acquisition: write with 1 starts, write with 0 converts
`default_nettype none

package adcp_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_TIME_NS = 3600;
  localparam int CONV_CYC =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXT_CONV_TICKS = 13;
  localparam int ACQ_TICKS = 3;
  localparam int CNT_W = 6;
  // result and buffering
  localparam int RES_W = 10;
  localparam int FIFO_DEPTH = 16;
  localparam int NUM_CH = 8;
  // control byte fields
  localparam int PD_HI = 7;
  localparam int PD_LO = 6;
  localparam int ACQ_BIT = 5;
  localparam int CFG_BIT = 4;
  localparam int POL_BIT = 3;
  localparam int CH_MSB = 2;
  localparam logic [1:0] PD_FULL = 2'h0;
  localparam logic [1:0] PD_STBY = 2'h1;
  // sync bundle positions
  localparam int SY_CS = 12;
  localparam int SY_WR = 11;
  localparam int SY_RD = 10;
  localparam int SY_HB = 9;
  localparam int SY_CK = 8;
  localparam int SY_W = 13;
  // reset values
  localparam logic RESET_EXT_CLK = 1'b1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ = 2'b01,
    ST_CONV = 2'b10,
    ST_PUSH = 2'b11
  } adcp_state_e;

  typedef enum logic [1:0] {
    PW_NORMAL = 2'b00,
    PW_STBY = 2'b01,
    PW_OFF = 2'b10
  } adcp_power_e;
endpackage

`default_nettype wire

// ===== rtl/adcp_port.sv
`default_nettype none

// ****************************************************************
// result buffer
// ****************************************************************
module adcp_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // honest full and empty from the word count
  assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;

  // storage
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  // pointers and count
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ****************************************************************
// parallel control and readout port
// ****************************************************************
module adcp_port #(
  parameter int NUM_CH = adcp_pkg::NUM_CH,
  parameter int FIFO_DEPTH = adcp_pkg::FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  input wire logic i_high_byte_select,
  input wire logic i_conv_clk,
  input wire logic [7:0] i_data_bus_pins,
  output logic [7:0] o_data_bus_pins,
  output logic o_data_bus_pins_oe,
  output logic o_conv_done_n,
  input wire logic [adcp_pkg::RES_W-1:0] i_sample_code,
  output logic o_track,
  output logic o_converting,
  output logic o_powered,
  output logic o_ext_clk_mode,
  output logic [2:0] o_mux_pos,
  output logic [2:0] o_mux_neg,
  output logic o_mux_neg_com
);
  localparam int RW = adcp_pkg::RES_W;
  localparam int FW = RW + 1;

  if (NUM_CH != 4 && NUM_CH != 8) begin : g_chk
    $error("channel count must be 4 or 8");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  // power code of a control byte to the state after the conversion
  function automatic adcp_pkg::adcp_power_e pd_to_power(
    input logic [1:0] pd
  );
    adcp_pkg::adcp_power_e p;
    p = adcp_pkg::PW_NORMAL;
    if (pd == adcp_pkg::PD_FULL) begin
      p = adcp_pkg::PW_OFF;
    end else if (pd == adcp_pkg::PD_STBY) begin
      p = adcp_pkg::PW_STBY;
    end
    return p;
  endfunction

  // front end code is offset binary; bipolar flips the msb
  function automatic logic [RW-1:0] fmt_result(
    input logic [RW-1:0] code,
    input logic unipolar
  );
    logic [RW-1:0] r;
    r = code;
    if (!unipolar) begin
      r[RW-1] = ~code[RW-1];
    end
    return r;
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  localparam int SW = adcp_pkg::SY_W;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;

  // two flops for every pin before any logic reads it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1_reg <= {5'h1f, 8'h00};
      sync2_reg <= {5'h1f, 8'h00};
    end else begin
      sync1_reg <= {i_cs_n, i_wr_n, i_rd_n, i_high_byte_select,
                    i_conv_clk, i_data_bus_pins};
      sync2_reg <= sync1_reg;
    end
  end

  logic sel;
  logic wr_act;
  logic rd_act;
  logic ck_lvl;
  logic [7:0] data_s;
  assign sel = ~sync2_reg[adcp_pkg::SY_CS];
  // strobes and clock count only while selected
  assign wr_act = sel & ~sync2_reg[adcp_pkg::SY_WR];
  assign rd_act = sel & ~sync2_reg[adcp_pkg::SY_RD];
  assign ck_lvl = sel & sync2_reg[adcp_pkg::SY_CK];
  assign data_s = sync2_reg[7:0];

  // ****************************************************************
  // strobe edges
  // ****************************************************************
  logic wr_prev_reg;
  logic rd_prev_reg;
  logic ck_prev_reg;
  logic hbe_hold_reg;
  logic [7:0] byte_hold_reg;

  // previous levels and the byte seen while the write is low
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_prev_reg <= 1'b0;
      rd_prev_reg <= 1'b0;
      ck_prev_reg <= 1'b0;
      hbe_hold_reg <= 1'b0;
      byte_hold_reg <= 8'h00;
    end else begin
      wr_prev_reg <= wr_act;
      rd_prev_reg <= rd_act;
      ck_prev_reg <= ck_lvl;
      if (wr_act) begin
        byte_hold_reg <= data_s; // all eight pins
      end
      if (rd_act) begin
        hbe_hold_reg <= sync2_reg[adcp_pkg::SY_HB];
      end
    end
  end

  logic wr_rise;
  logic rd_start;
  logic rd_end;
  logic ck_rise;
  assign wr_rise = wr_prev_reg & ~wr_act;
  assign rd_start = rd_act & ~rd_prev_reg;
  assign rd_end = rd_prev_reg & ~rd_act;
  assign ck_rise = ck_lvl & ~ck_prev_reg;

  // control byte fields
  logic [1:0] new_pd;
  logic new_acq;
  logic [2:0] new_ch;
  assign new_pd = {byte_hold_reg[adcp_pkg::PD_HI],
                   byte_hold_reg[adcp_pkg::PD_LO]};
  assign new_acq = byte_hold_reg[adcp_pkg::ACQ_BIT];
  assign new_ch = {byte_hold_reg[adcp_pkg::CH_MSB] && NUM_CH == 8,
                   byte_hold_reg[adcp_pkg::CH_MSB-1:0]};

  // ****************************************************************
  // configuration
  // ****************************************************************
  logic ext_clk_reg;
  logic unipolar_reg;

  // clock source kept through power-down codes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext_clk_reg <= adcp_pkg::RESET_EXT_CLK;
      unipolar_reg <= 1'b1;
    end else if (wr_rise) begin
      if (new_pd[1]) begin
        ext_clk_reg <= new_pd[0];
      end
      unipolar_reg <= byte_hold_reg[adcp_pkg::POL_BIT];
    end
  end

  // input multiplexer selection
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mux_pos <= 3'h0;
      o_mux_neg <= 3'h0;
      o_mux_neg_com <= 1'b1;
    end else if (wr_rise) begin
      if (byte_hold_reg[adcp_pkg::CFG_BIT]) begin
        o_mux_pos <= new_ch;
        o_mux_neg <= new_ch;
        o_mux_neg_com <= 1'b1;
      end else begin
        o_mux_pos <= new_ch;
        o_mux_neg <= {new_ch[2:1], ~new_ch[0]};
        o_mux_neg_com <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // acquisition and conversion sequencer
  // ****************************************************************
  adcp_pkg::adcp_state_e st_reg;
  adcp_pkg::adcp_power_e power_reg;
  adcp_pkg::adcp_power_e pend_reg;
  logic acq_ext_reg;
  logic [adcp_pkg::CNT_W-1:0] cnt_reg;
  logic [RW-1:0] samp_reg;
  logic tick;
  logic [adcp_pkg::CNT_W-1:0] conv_last;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [FW-1:0] fifo_in_data;
  logic push_done;

  // internal clock steps every cycle, else the external clock
  assign tick = ext_clk_reg ? ck_rise : 1'b1;
  assign conv_last = ext_clk_reg ?
    adcp_pkg::CNT_W'(adcp_pkg::EXT_CONV_TICKS - 1) :
    adcp_pkg::CNT_W'(adcp_pkg::CONV_CYC - 1);
  assign fifo_in_valid = (st_reg == adcp_pkg::ST_PUSH);
  assign fifo_in_data = {unipolar_reg,
                         fmt_result(samp_reg, unipolar_reg)};
  assign push_done = fifo_in_valid && fifo_in_ready;

  // a write wakes the part and steers the sequence
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= adcp_pkg::ST_IDLE;
      power_reg <= adcp_pkg::PW_NORMAL;
      pend_reg <= adcp_pkg::PW_NORMAL;
      acq_ext_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (wr_rise) begin
      power_reg <= adcp_pkg::PW_NORMAL;
      pend_reg <= pd_to_power(new_pd);
      unique case (st_reg)
        adcp_pkg::ST_IDLE: begin
          st_reg <= adcp_pkg::ST_ACQ;
          acq_ext_reg <= new_acq;
          cnt_reg <= '0;
        end
        adcp_pkg::ST_ACQ: begin
          if (acq_ext_reg && !new_acq) begin
            st_reg <= adcp_pkg::ST_CONV;
            cnt_reg <= '0;
          end
        end
        adcp_pkg::ST_CONV, adcp_pkg::ST_PUSH: begin
          st_reg <= st_reg; // running conversion completes
        end
      endcase
    end else begin
      unique case (st_reg)
        adcp_pkg::ST_IDLE: begin
          st_reg <= adcp_pkg::ST_IDLE; // no conversion while down
        end
        adcp_pkg::ST_ACQ: begin
          if (!acq_ext_reg && tick) begin
            if (cnt_reg ==
                adcp_pkg::CNT_W'(adcp_pkg::ACQ_TICKS - 1)) begin
              st_reg <= adcp_pkg::ST_CONV;
              cnt_reg <= '0;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
        end
        adcp_pkg::ST_CONV: begin
          if (tick) begin
            if (cnt_reg == conv_last) begin
              st_reg <= adcp_pkg::ST_PUSH;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
        end
        adcp_pkg::ST_PUSH: begin
          if (fifo_in_ready) begin
            st_reg <= adcp_pkg::ST_IDLE;
            power_reg <= pend_reg; // power down after the result
          end
        end
      endcase
    end
  end

  // hold the sample taken as acquisition ends
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      samp_reg <= '0;
    end else if (st_reg == adcp_pkg::ST_ACQ) begin
      samp_reg <= i_sample_code;
    end
  end

  // ****************************************************************
  // result buffer and readout
  // ****************************************************************
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out_data;
  logic fifo_pop;
  logic done_reg;
  logic [RW-1:0] head;
  logic head_uni;

  // pop once the high byte has been read
  assign fifo_pop = rd_end && hbe_hold_reg;
  assign head = fifo_out_data[RW-1:0];
  assign head_uni = fifo_out_data[RW];

  adcp_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(fifo_in_valid),
    .i_in_data(fifo_in_data),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(fifo_pop)
  );

  // result ready flag; a new result wins over a clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      done_reg <= 1'b0;
    end else if (push_done) begin
      done_reg <= 1'b1;
    end else if (rd_start || wr_rise) begin
      done_reg <= 1'b0;
    end
  end

  // data pins driven only during a selected read
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_data_bus_pins <= 8'h00;
      o_data_bus_pins_oe <= 1'b0;
    end else begin
      o_data_bus_pins_oe <= rd_act;
      if (sync2_reg[adcp_pkg::SY_HB]) begin
        o_data_bus_pins <= {{6{head[RW-1] & ~head_uni}},
                            head[RW-1:8]};
      end else begin
        o_data_bus_pins <= head[7:0];
      end
    end
  end

  // status outputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_conv_done_n <= 1'b1;
      o_track <= 1'b0;
      o_converting <= 1'b0;
      o_powered <= 1'b1;
      o_ext_clk_mode <= adcp_pkg::RESET_EXT_CLK;
    end else begin
      o_conv_done_n <= ~done_reg;
      o_track <= (st_reg == adcp_pkg::ST_ACQ);
      o_converting <= (st_reg == adcp_pkg::ST_CONV);
      o_powered <= (power_reg == adcp_pkg::PW_NORMAL);
      o_ext_clk_mode <= ext_clk_reg;
    end
  end
endmodule

`default_nettype wire

// ===== test/adcp_port_asserts.sv
`default_nettype none

// ****************************************************************
// port checker
// ****************************************************************
module adcp_port_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  input wire logic i_high_byte_select,
  input wire logic i_conv_clk,
  input wire logic [7:0] o_data_bus_pins,
  input wire logic o_data_bus_pins_oe,
  input wire logic o_conv_done_n,
  input wire logic o_track,
  input wire logic o_converting,
  input wire logic o_powered,
  input wire logic o_ext_clk_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_reg;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // cycles spent converting so far
  always_ff @(posedge i_clk) begin
    if (i_rst || !o_converting) cnt_reg <= 8'h0;
    else cnt_reg <= cnt_reg + 8'h1;
  end

  sequence s_wr_rise;
    !i_cs_n && $rose(i_wr_n);
  endsequence
  sequence s_rd_hold;
    (!i_cs_n && !i_rd_n) [*6];
  endsequence

  reset_vals_a: assert property (
    $fell(i_rst) |-> o_conv_done_n && o_ext_clk_mode && o_powered
      && !o_data_bus_pins_oe && !o_track)
    else $error("wrong state after reset");
  cs_hiz_a: assert property (
    i_cs_n [*5] |-> !o_data_bus_pins_oe)
    else $error("data pins driven while deselected");
  wr_acq_a: assert property (
    s_wr_rise ##0 (!o_track && !o_converting) |-> ##[2:6] o_track)
    else $error("write did not start acquisition");
  done_clear_a: assert property (
    s_rd_hold |-> o_conv_done_n)
    else $error("done flag held through a read");
  high_byte_a: assert property (
    (o_data_bus_pins_oe && i_high_byte_select) [*5] |->
      o_data_bus_pins[7:2] == 6'h0 ||
      o_data_bus_pins[7:2] == {6{o_data_bus_pins[1]}})
    else $error("high byte upper pins malformed");
  pd_idle_a: assert property (
    !o_powered |-> !o_converting)
    else $error("conversion while powered down");
  ext_hold_a: assert property (
    (o_ext_clk_mode && !i_conv_clk) [*8] ##0 $past(o_converting)
      |-> o_converting)
    else $error("conversion ended without clock edges");
  conv_time_a: assert property (
    $fell(o_converting) && !o_ext_clk_mode |->
      cnt_reg == adcp_pkg::CONV_CYC)
    else $error("internal conversion length wrong");
endmodule

bind adcp_port adcp_port_chk u_adcp_port_chk (
  .i_clk, .i_rst, .i_cs_n, .i_wr_n, .i_rd_n, .i_high_byte_select,
  .i_conv_clk, .o_data_bus_pins, .o_data_bus_pins_oe, .o_conv_done_n,
  .o_track, .o_converting, .o_powered, .o_ext_clk_mode
);

`default_nettype wire

// ===== test/adcp_host_bfm.sv
`default_nettype none

// ****************************************************************
// microprocessor bus model
// ****************************************************************
module adcp_host_bfm (
  input wire logic i_clk,
  input wire logic [7:0] i_dev_data,
  input wire logic i_dev_oe,
  output logic o_cs_n,
  output logic o_wr_n,
  output logic o_rd_n,
  output logic o_hbe,
  output logic o_cclk,
  output logic [7:0] o_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] drv;
  logic [7:0] last = 8'h00;
  logic drv_en;

  // resolved pins: device, host, else inverse of last value
  assign o_bus = i_dev_oe ? i_dev_data : (drv_en ? drv : ~last);

  // remember the last driven value
  always @(posedge i_clk) begin
    if (i_dev_oe || drv_en) last <= o_bus;
  end

  // idle levels
  initial begin
    {o_cs_n, o_wr_n, o_rd_n} = 3'h7;
    {o_hbe, o_cclk, drv_en} = 3'h0;
    drv = 8'h0;
  end

  // control byte write cycle
  task automatic wr(input logic [7:0] b);
    @(negedge i_clk);
    o_cs_n = 0;
    drv = b;
    drv_en = 1;
    o_wr_n = 0;
    repeat (4) @(negedge i_clk);
    o_wr_n = 1;
    repeat (2) @(negedge i_clk);
    drv_en = 0;
    o_cs_n = 1;
    repeat (4) @(negedge i_clk);
  endtask

  // low then high byte, select and strobe low throughout
  task automatic rd(output logic [15:0] r);
    @(negedge i_clk);
    o_cs_n = 0;
    o_rd_n = 0;
    repeat (5) @(negedge i_clk);
    r[7:0] = o_bus;
    o_hbe = 1;
    repeat (4) @(negedge i_clk);
    r[15:8] = o_bus;
    o_rd_n = 1;
    o_cs_n = 1;
    repeat (5) @(negedge i_clk);
    o_hbe = 0;
  endtask

  // strobes with the device deselected
  task automatic stray(input logic [7:0] b);
    @(negedge i_clk);
    drv = b;
    drv_en = 1;
    o_wr_n = 0;
    o_rd_n = 0;
    repeat (6) @(negedge i_clk);
    o_wr_n = 1;
    repeat (4) @(negedge i_clk);
    o_rd_n = 1;
    drv_en = 0;
    repeat (4) @(negedge i_clk);
  endtask

  // 1.25 MHz conversion clock, 50% duty, selected, moved on falling edges
  task automatic cclk(input int n);
    @(negedge i_clk);
    o_cs_n = 0;
    repeat (n) begin
      repeat (4) @(negedge i_clk);
      o_cclk = 1;
      repeat (4) @(negedge i_clk);
      o_cclk = 0;
    end
    o_cs_n = 1;
  endtask
endmodule

`default_nettype wire

// ===== test/test_adcp_port.sv
`default_nettype none

// ****************************************************************
// testbench
// ****************************************************************
module test_adcp_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_rst, cs_n, wr_n, rd_n, hbe, cclk;
  logic oe, done_n, trk, conv, pwr, extm, ncom;
  logic [7:0] bus, dout;
  logic [2:0] mp, mn;
  logic [9:0] smp;
  logic [1:0] wr_st;
  logic [15:0] q[$];
  int errors, num_checks, i;

  adcp_port u_adcp_port (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n),
    .i_wr_n(wr_n), .i_rd_n(rd_n), .i_high_byte_select(hbe),
    .i_conv_clk(cclk), .i_data_bus_pins(bus), .o_data_bus_pins(dout),
    .o_data_bus_pins_oe(oe), .o_conv_done_n(done_n),
    .i_sample_code(smp), .o_track(trk), .o_converting(conv),
    .o_powered(pwr), .o_ext_clk_mode(extm), .o_mux_pos(mp),
    .o_mux_neg(mn), .o_mux_neg_com(ncom));
  adcp_host_bfm u_adcp_host_bfm (.i_clk(i_clk), .i_dev_data(dout),
    .i_dev_oe(oe), .o_cs_n(cs_n), .o_wr_n(wr_n), .o_rd_n(rd_n),
    .o_hbe(hbe), .o_cclk(cclk), .o_bus(bus));

  // system clock
  initial begin
    i_clk = 0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // bounded wait for one conversion to run and land
  task automatic wait_conv();
    int n;
    n = 0;
    while (conv !== 1'b1 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    if (conv !== 1'b1) n = 1000;
    while (conv !== 1'b0 && n < 1000) begin
      @(negedge i_clk);
      n++;
    end
    if (n > 999) begin
      errors++;
      $display("CHECK FAILED t=%0t conversion timeout", $time);
    end
    repeat (4) @(negedge i_clk);
  endtask

  // write a byte and queue its expected two-byte result
  task automatic cv(input logic [7:0] b, input logic [9:0] s,
                    input logic w);
    logic [9:0] c;
    smp = s;
    u_adcp_host_bfm.wr(b);
    wr_st = {done_n, pwr};
    c = b[3] ? s : {~s[9], s[8:0]};
    q.push_back({b[3] ? 6'h0 : {6{c[9]}}, c});
    if (w) wait_conv();
  endtask

  task automatic drain();
    logic [15:0] e, r;
    while (q.size() > 0) begin
      e = q.pop_front();
      u_adcp_host_bfm.rd(r);
      chk(r[7:0], e[7:0]);
      chk(r[15:8], e[15:8]);
    end
  endtask

  // watchdog
  initial begin
    #2_000_000;
    errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    print_verdict();
  end

  // main sequence
  initial begin
    i_rst = 1;
    smp = 10'h0;
    repeat (3) @(negedge i_clk);
    i_rst = 0;
    chk({4'h0, done_n, extm, oe, pwr}, 8'h0d);
    // reset interval and reference settling before the first conversion
    repeat (5000) @(negedge i_clk);
    cv(8'h9d, 10'h2c6, 1);
    chk({3'h0, extm, ncom, mp}, 8'h0d);
    chk({7'h0, done_n}, 8'h00);
    cv(8'h83, 10'h0a5, 1);
    chk({6'h0, wr_st}, 8'h03);
    chk({1'b0, ncom, mn, mp}, 8'h13);
    drain();
    chk({7'h0, done_n}, 8'h01);
    // sixteen conversions fill the buffer, one more stalls
    for (i = 0; i < 8; i++) begin
      cv({5'h10, i[2:0]}, {i[2:0], 7'h2a}, 1);
      chk({1'b0, ncom, mn, mp}, {2'h0, i[2:0] ^ 3'h1, i[2:0]});
      cv({5'h13, i[2:0]}, {~i[2:0], 7'h55}, 1);
      chk({4'h0, ncom, mp}, {5'h01, i[2:0]});
    end
    cv(8'h9a, 10'h311, 1);
    drain();
    // external conversion clock, stalled then run
    cv(8'hd8, 10'h3a7, 0);
    repeat (20) @(negedge i_clk);
    chk({4'h0, trk, conv, done_n, extm}, 8'h0b);
    u_adcp_host_bfm.cclk(6);
    repeat (20) @(negedge i_clk);
    chk({4'h0, trk, conv, done_n, extm}, 8'h07);
    fork
      u_adcp_host_bfm.cclk(16);
      wait_conv();
    join
    // externally timed acquisition
    u_adcp_host_bfm.wr(8'hb8);
    repeat (60) @(negedge i_clk);
    chk({6'h0, trk, conv}, 8'h02);
    cv(8'h98, 10'h155, 1);
    // standby and shutdown
    cv(8'h58, 10'h3ff, 1);
    chk({6'h0, pwr, extm}, 8'h00);
    drain();
    cv(8'h98, 10'h001, 1);
    chk({6'h0, wr_st}, 8'h03);
    cv(8'h18, 10'h200, 1);
    chk({6'h0, pwr, extm}, 8'h00);
    cv(8'h98, 10'h0f0, 1);
    chk({6'h0, wr_st}, 8'h03);
    // settling time after waking, external reference case
    repeat (500) @(negedge i_clk);
    drain();
    u_adcp_host_bfm.stray(8'hd8);
    chk({5'h0, oe, trk, extm}, 8'h00);
    print_verdict();
  end
endmodule

`default_nettype wire
